//--- hdl/auto_fan_control_params.v
/*
 register bank and per-fan automatic drive loop for two fans.
 assumes a synchronous byte register port, tach pulses as one-cycle
 strobes, and per-source temperatures that fanSource1/fanSource2 select per fan here.
*/
`timescale 1ns/1ps
`include "fan_loop_consts.vh"
module auto_fan_control_params (
   input wire ref_clk,
   input wire rst,
   input wire regWrite,
   input wire regRead,
   input wire [7:0] regAddr,
   input wire [7:0] regWdata,
   output reg [7:0] regRdata,
   input wire stepEn,
   input wire [1:0] fanSource1,
   input wire [1:0] fanSource2,
   input wire [7:0] srcTemp0,
   input wire [7:0] srcTemp1,
   input wire [7:0] srcTemp2,
   input wire [7:0] srcTemp3,
   input wire [7:0] srcStart0,
   input wire [7:0] srcStart1,
   input wire [7:0] srcStart2,
   input wire [7:0] srcStart3,
   input wire autoMode,
   input wire faultMode,
   input wire tach1,
   input wire tach2,
   output reg [7:0] fanOutputOne,
   output reg [7:0] fanOutputTwo,
   output reg fanStarting1,
   output reg fanStarting2
);
   reg [7:0] thermRange_q, rlRange_q, thermHyst_q, rlHyst_q;
   reg [7:0] start1_q, start2_q, min1_q, min2_q, ceil1_q, ceil2_q, quiet_q, fault_q;
   reg on1_q, on2_q;
   reg [1:0] spin1_q, spin2_q;
   wire [7:0] tgt1, tgt2;
   wire wantOn1, wantOn2, keepOn1, keepOn2;

   // ramp width in 1/3 degree units: 2,2.67,3.33,...,80
   function [7:0] rampThirds;
      input [3:0] code;
      begin
         case (code)
            4'h0: rampThirds = 8'h06;
            4'h1: rampThirds = 8'h08;
            4'h2: rampThirds = 8'h0a;
            4'h3: rampThirds = 8'h0c;
            4'h4: rampThirds = 8'h0f;
            4'h5: rampThirds = 8'h14;
            4'h6: rampThirds = 8'h18;
            4'h7: rampThirds = 8'h1e;
            4'h8: rampThirds = 8'h28;
            4'h9: rampThirds = 8'h30;
            4'ha: rampThirds = 8'h3c;
            4'hb: rampThirds = 8'h50;
            4'hc: rampThirds = 8'h60;
            4'hd: rampThirds = 8'h78;
            4'he: rampThirds = 8'ha0;
            default: rampThirds = 8'hf0;
         endcase
      end
   endfunction

   // step code to duty change
   function [7:0] stepSize;
      input [2:0] code;
      begin
         case (code)
            3'h0: stepSize = 8'h01;
            3'h1: stepSize = 8'h02;
            3'h2: stepSize = 8'h03;
            3'h3: stepSize = 8'h05;
            3'h4: stepSize = 8'h08;
            3'h5: stepSize = 8'h0c;
            3'h6: stepSize = 8'h18;
            default: stepSize = 8'h30;
         endcase
      end
   endfunction

   // source select: 0 first therm/remote2, 1 second therm, 2 remote, 3 local
   function [3:0] rangeCode;
      input [1:0] src;
      input [7:0] tr;
      input [7:0] rl;
      begin
         case (src)
            2'h0: rangeCode = tr[7:4];
            2'h1: rangeCode = tr[3:0];
            2'h2: rangeCode = rl[7:4];
            default: rangeCode = rl[3:0];
         endcase
      end
   endfunction

   function [3:0] hystCode;
      input [1:0] src;
      input [7:0] th;
      input [7:0] rh;
      begin
         case (src)
            2'h0: hystCode = th[7:4];
            2'h1: hystCode = th[3:0];
            2'h2: hystCode = rh[7:4];
            default: hystCode = rh[3:0];
         endcase
      end
   endfunction

   function [7:0] pick;
      input [1:0] src;
      input [7:0] a, b, c, d;
      begin
         case (src)
            2'h0: pick = a;
            2'h1: pick = b;
            2'h2: pick = c;
            default: pick = d;
         endcase
      end
   endfunction

   // linear ramp from min level to full drive across the range
   function [7:0] rampTarget;
      input [7:0] temp, ramp_start_temperature, minLvl, ceil;
      input [3:0] rcode;
      reg [8:0] above;
      reg [7:0] width;
      reg [17:0] prod;
      reg [8:0] lvl;
      reg [17:0] quo;
      begin
         above = {1'b0, temp} - {1'b0, ramp_start_temperature};
         width = rampThirds(rcode);
         prod = 18'h0;
         quo = 18'h0;
         lvl = {1'b0, `FULL_DRIVE};
         if (temp > ramp_start_temperature) begin
            prod = {10'h0, above[7:0]} * 18'h00003 * {10'h0, `FULL_DRIVE - minLvl};
            if ({2'b0, above[7:0]} * 10'h003 < {2'b0, width}) begin
               quo = prod / {10'h0, width};
               lvl = {1'b0, minLvl} + quo[8:0];
            end
         end else begin
            lvl = {1'b0, minLvl};
         end
         if (lvl[7:0] > ceil) begin
            rampTarget = ceil;
         end else begin
            rampTarget = lvl[7:0];
         end
      end
   endfunction

   // move current drive toward target by at most one step when limit is set, else straight to target
   function [7:0] slew;
      input [7:0] cur, tgt, step;
      input limit;
      begin
         if (!limit) begin
            slew = tgt;
         end else if (tgt > cur) begin
            slew = (tgt - cur > step) ? cur + step : tgt;
         end else begin
            slew = (cur - tgt > step) ? cur - step : tgt;
         end
      end
   endfunction

   assign tgt1 = rampTarget(pick(fanSource1, srcTemp0, srcTemp1, srcTemp2, srcTemp3),
      pick(fanSource1, srcStart0, srcStart1, srcStart2, srcStart3), min1_q, ceil1_q,
      rangeCode(fanSource1, thermRange_q, rlRange_q));
   assign tgt2 = rampTarget(pick(fanSource2, srcTemp0, srcTemp1, srcTemp2, srcTemp3),
      pick(fanSource2, srcStart0, srcStart1, srcStart2, srcStart3), min2_q, ceil2_q,
      rangeCode(fanSource2, thermRange_q, rlRange_q));
   assign wantOn1 = pick(fanSource1, srcTemp0, srcTemp1, srcTemp2, srcTemp3)
      > pick(fanSource1, srcStart0, srcStart1, srcStart2, srcStart3);
   assign wantOn2 = pick(fanSource2, srcTemp0, srcTemp1, srcTemp2, srcTemp3)
      > pick(fanSource2, srcStart0, srcStart1, srcStart2, srcStart3);
   // sum form: no wrap when start is below hysteresis
   assign keepOn1 = {2'b0, pick(fanSource1, srcTemp0, srcTemp1, srcTemp2, srcTemp3)} + 10'h001
      + {6'h0, hystCode(fanSource1, thermHyst_q, rlHyst_q)}
      > {2'b0, pick(fanSource1, srcStart0, srcStart1, srcStart2, srcStart3)};
   assign keepOn2 = {2'b0, pick(fanSource2, srcTemp0, srcTemp1, srcTemp2, srcTemp3)} + 10'h001
      + {6'h0, hystCode(fanSource2, thermHyst_q, rlHyst_q)}
      > {2'b0, pick(fanSource2, srcStart0, srcStart1, srcStart2, srcStart3)};

   // register writes
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         thermRange_q <= `RST_RANGE;
         rlRange_q <= `RST_RANGE;
         thermHyst_q <= `RST_HYST;
         rlHyst_q <= `RST_HYST;
         start1_q <= `RST_START;
         start2_q <= `RST_START;
         min1_q <= `RST_MIN;
         min2_q <= `RST_MIN;
         ceil1_q <= `RST_CEIL;
         ceil2_q <= `RST_CEIL;
         quiet_q <= `RST_QUIET;
         fault_q <= `RST_FAULT;
      end else if (regWrite) begin
         if (regAddr == `ADDR_THERM_RANGE) begin
            thermRange_q <= regWdata;
         end else if (regAddr == `ADDR_RL_RANGE) begin
            rlRange_q <= regWdata;
         end else if (regAddr == `ADDR_THERM_HYST) begin
            thermHyst_q <= regWdata;
         end else if (regAddr == `ADDR_RL_HYST) begin
            rlHyst_q <= regWdata;
         end else if (regAddr == `ADDR_START1) begin
            start1_q <= regWdata;
         end else if (regAddr == `ADDR_START2) begin
            start2_q <= regWdata;
         end else if (regAddr == `ADDR_MIN1) begin
            min1_q <= regWdata;
         end else if (regAddr == `ADDR_MIN2) begin
            min2_q <= regWdata;
         end else if (regAddr == `ADDR_CEIL1) begin
            ceil1_q <= regWdata;
         end else if (regAddr == `ADDR_CEIL2) begin
            ceil2_q <= regWdata;
         end else if (regAddr == `ADDR_QUIET) begin
            quiet_q <= regWdata;
         end else if (regAddr == `ADDR_FAULT) begin
            fault_q <= regWdata & `FAULT_MASK;
         end
      end
   end

   // register read, registered one cycle
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         regRdata <= 8'h00;
      end else if (regRead) begin
         if (regAddr == `ADDR_THERM_RANGE) begin
            regRdata <= thermRange_q;
         end else if (regAddr == `ADDR_RL_RANGE) begin
            regRdata <= rlRange_q;
         end else if (regAddr == `ADDR_THERM_HYST) begin
            regRdata <= thermHyst_q;
         end else if (regAddr == `ADDR_RL_HYST) begin
            regRdata <= rlHyst_q;
         end else if (regAddr == `ADDR_START1) begin
            regRdata <= start1_q;
         end else if (regAddr == `ADDR_START2) begin
            regRdata <= start2_q;
         end else if (regAddr == `ADDR_MIN1) begin
            regRdata <= min1_q;
         end else if (regAddr == `ADDR_MIN2) begin
            regRdata <= min2_q;
         end else if (regAddr == `ADDR_CEIL1) begin
            regRdata <= ceil1_q;
         end else if (regAddr == `ADDR_CEIL2) begin
            regRdata <= ceil2_q;
         end else if (regAddr == `ADDR_QUIET) begin
            regRdata <= quiet_q;
         end else if (regAddr == `ADDR_FAULT) begin
            regRdata <= fault_q & `FAULT_MASK;
         end else begin
            regRdata <= 8'h00;
         end
      end
   end

   // fan 1 drive: off, spin-up, run
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         on1_q <= 1'b0;
         spin1_q <= 2'h0;
         fanStarting1 <= 1'b0;
         fanOutputOne <= 8'h00;
      end else if (!on1_q) begin
         fanOutputOne <= 8'h00;
         if (autoMode && wantOn1) begin
            on1_q <= 1'b1;
            spin1_q <= 2'h0;
            fanStarting1 <= 1'b1;
            fanOutputOne <= start1_q;
         end
      end else if (fanStarting1) begin
         if (tach1) begin
            spin1_q <= spin1_q + 2'h1;
            if (spin1_q + 2'h1 == `START_TACH_PERIODS) begin
               fanStarting1 <= 1'b0;
               fanOutputOne <= min1_q;
            end
         end
      end else if (!autoMode || !keepOn1) begin
         on1_q <= 1'b0;
         fanOutputOne <= 8'h00;
      end else if (stepEn) begin
         if (faultMode) begin
            fanOutputOne <= slew(fanOutputOne, `FULL_DRIVE, stepSize(fault_q[2:0]), 1'b1);
         end else begin
            fanOutputOne <= slew(fanOutputOne, tgt1, stepSize(quiet_q[2:0]),
               quiet_q[`QUIET_EN1_BIT]);
         end
      end
   end

   // fan 2 drive
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         on2_q <= 1'b0;
         spin2_q <= 2'h0;
         fanStarting2 <= 1'b0;
         fanOutputTwo <= 8'h00;
      end else if (!on2_q) begin
         fanOutputTwo <= 8'h00;
         if (autoMode && wantOn2) begin
            on2_q <= 1'b1;
            spin2_q <= 2'h0;
            fanStarting2 <= 1'b1;
            fanOutputTwo <= start2_q;
         end
      end else if (fanStarting2) begin
         if (tach2) begin
            spin2_q <= spin2_q + 2'h1;
            if (spin2_q + 2'h1 == `START_TACH_PERIODS) begin
               fanStarting2 <= 1'b0;
               fanOutputTwo <= min2_q;
            end
         end
      end else if (!autoMode || !keepOn2) begin
         on2_q <= 1'b0;
         fanOutputTwo <= 8'h00;
      end else if (stepEn) begin
         if (faultMode) begin
            fanOutputTwo <= slew(fanOutputTwo, `FULL_DRIVE, stepSize(fault_q[5:3]), 1'b1);
         end else begin
            fanOutputTwo <= slew(fanOutputTwo, tgt2, stepSize(quiet_q[5:3]),
               quiet_q[`QUIET_EN2_BIT]);
         end
      end
   end
endmodule

//--- hdl/fan_loop_consts.vh
/*
 fan loop constants: register offsets, reset values, field positions.
 assumes inclusion by the single fan loop register bank module.
*/
// Behaviour
// - low range nibble sets second thermistor ramp
// - high range nibble sets first thermistor ramp
// - remote/local low nibble sets local ramp
// - remote/local high nibble sets remote ramp
// - range codes map to sixteen ramp widths
// - thermistor hysteresis nibbles, one degree steps
// - remote/local hysteresis nibbles, one degree steps
// - start-up level for two tach periods
// - never below minimum level after spin-up unless the ceiling is set lower
// - automatic mode caps drive at ceiling except during spin-up and in fault mode; spin-up exit loads the minimum level, uncapped until stepped down
// - quiet step fields bound duty change
// - quiet limiting enabled per fan bits
// - fault mode step per fan field
// - fault register top bits ignored, read zero
// - power-up defaults per register
// - ramp starts above minimum temperature
`ifndef FAN_LOOP_CONSTS_VH
`define FAN_LOOP_CONSTS_VH
`define ADDR_THERM_RANGE 8'h2c
`define ADDR_RL_RANGE 8'h2d
`define ADDR_THERM_HYST 8'h2e
`define ADDR_RL_HYST 8'h2f
`define ADDR_START1 8'h30
`define ADDR_START2 8'h31
`define ADDR_MIN1 8'h32
`define ADDR_MIN2 8'h33
`define ADDR_CEIL1 8'h34
`define ADDR_CEIL2 8'h35
`define ADDR_QUIET 8'h36
`define ADDR_FAULT 8'h37
`define RST_RANGE 8'hcc
`define RST_HYST 8'h44
`define RST_START 8'h80
`define RST_MIN 8'h60
`define RST_CEIL 8'h20
`define RST_QUIET 8'h3f
`define RST_FAULT 8'h3f
`define FAULT_MASK 8'h3f
`define QUIET_EN1_BIT 6
`define QUIET_EN2_BIT 7
`define START_TACH_PERIODS 2'h2
`define FULL_DRIVE 8'hff
`endif

//--- tb/auto_fan_control_params_tb_top.sv
/* self-checking bench for the fan loop register bank
   assumes fan tach models on both drive outputs */
`timescale 1ns/1ps
module auto_fan_control_params_tb_top;
   localparam [63:0] STEPS = {8'h30, 8'h18, 8'h0c, 8'h08, 8'h05, 8'h03, 8'h02, 8'h01};
   localparam [127:0] WIDE = {8'h50, 8'h36, 8'h28, 8'h20, 8'h1b, 8'h14, 8'h10, 8'h0e,
      8'h0a, 8'h08, 8'h07, 8'h05, 8'h04, 8'h04, 8'h03, 8'h02};
   localparam [95:0] DEF = {8'h3f, 8'h3f, 8'h20, 8'h20, 8'h60, 8'h60, 8'h80, 8'h80, 8'h44, 8'h44, 8'hcc, 8'hcc};
   reg ref_clk = 1'b0, rst = 1'b1, regWrite = 1'b0, regRead = 1'b0, stepEn = 1'b0;
   reg autoMode = 1'b0, faultMode = 1'b0, rdLate = 1'b0, probe = 1'b0, probe2 = 1'b0;
   reg [7:0] regAddr = 8'h00, regWdata = 8'h00, temp = 8'h00, base = 8'h00, c, v;
   reg [1:0] fanSource1 = 2'h0, fanSource2 = 2'h0;
   wire [7:0] regRdata, fanOutputOne, fanOutputTwo;
   wire tach1, tach2, fanStarting1, fanStarting2;
   reg [7:0] rdQ[$];
   reg [8:0] fanQ[$];
   reg [8:0] fan2Q[$];
   int miscompares = 0, checkCount = 0, i, h;
   auto_fan_control_params u_auto_fan_control_params (.ref_clk(ref_clk), .rst(rst),
      .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
      .stepEn(stepEn), .fanSource1(fanSource1), .fanSource2(fanSource2), .srcTemp0(temp), .srcTemp1(temp),
      .srcTemp2(temp), .srcTemp3(temp), .srcStart0(base), .srcStart1(base), .srcStart2(base),
      .srcStart3(base), .autoMode(autoMode), .faultMode(faultMode), .tach1(tach1), .tach2(tach2),
      .fanOutputOne(fanOutputOne), .fanOutputTwo(fanOutputTwo), .fanStarting1(fanStarting1),
      .fanStarting2(fanStarting2));
   fan_tach_model u_fan_tach_model (.refClk(ref_clk), .rst(rst), .drive(fanOutputOne), .tachPulse(tach1));
   fan_tach_model u_fan_tach_model_2 (.refClk(ref_clk), .rst(rst), .drive(fanOutputTwo), .tachPulse(tach2));
   always #2.5 ref_clk = ~ref_clk;
   task wr(input [7:0] a, input [7:0] d);
      @(posedge ref_clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge ref_clk);
      regWrite <= 1'b0;
   endtask
   task rd(input [7:0] a, input [7:0] e);
      rdQ.push_back(e);
      @(posedge ref_clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge ref_clk);
      regRead <= 1'b0;
   endtask
   // bit 8 of the note: drive must differ from the value
   task chk(input [8:0] e);
      fanQ.push_back(e);
      @(posedge ref_clk);
      probe <= 1'b1;
      @(posedge ref_clk);
      probe <= 1'b0;
   endtask
   // note for fan two: {starting, drive}
   task chk2(input [8:0] e);
      fan2Q.push_back(e);
      @(posedge ref_clk);
      probe2 <= 1'b1;
      @(posedge ref_clk);
      probe2 <= 1'b0;
   endtask
   task step(input [7:0] t);
      @(posedge ref_clk);
      temp <= t;
      stepEn <= 1'b1;
      @(posedge ref_clk);
      stepEn <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask
   task spinUp;
      int j;
      step(base + 8'h01);
      chk(9'h090);
      for (j = 0; j < 200 && fanStarting1 !== 1'b0; j++)
         @(posedge ref_clk);
      chk(9'h050);
   endtask
   task cmpRd(input [7:0] e);
      checkCount++;
      if (regRdata !== e) begin
         miscompares++;
         $display("ERROR regRdata expected %h seen %h", e, regRdata);
      end
   endtask
   task cmpFan(input [8:0] e);
      checkCount++;
      if ((fanOutputOne === e[7:0]) == e[8]) begin
         miscompares++;
         $display("ERROR fanOutputOne expected %s%h seen %h", e[8] ? "not " : "", e[7:0], fanOutputOne);
      end
   endtask
   task cmpFan2(input [8:0] e);
      checkCount++;
      if ({fanStarting2, fanOutputTwo} !== e) begin
         miscompares++;
         $display("ERROR fanStarting2/fanOutputTwo expected %h seen %h", e, {fanStarting2, fanOutputTwo});
      end
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", checkCount, miscompares);
      if (miscompares == 0 && checkCount > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      rdLate <= regRead;
      if (rdLate)
         cmpRd(rdQ.pop_front());
      if (probe)
         cmpFan(fanQ.pop_front());
      if (probe2)
         cmpFan2(fan2Q.pop_front());
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      miscompares++;
      wrap_up;
   end
   initial begin
      void'($urandom(32'hb1a1));
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      base <= 8'h20 + 8'($urandom % 128);
      fanSource2 <= 2'($urandom);
      for (i = 0; i < 12; i++)
         rd(8'h2c + 8'(i), DEF[i*8 +: 8]);
      wr(8'h37, 8'hff);
      rd(8'h37, 8'h3f);
      rd(8'h38, 8'h00);
      for (i = 0; i < 12; i++) begin
         c = 8'($urandom);
         wr(8'h2c + 8'(i), c);
         rd(8'h2c + 8'(i), i == 11 ? c & 8'h3f : c);
      end
      wr(8'h30, 8'h90);
      wr(8'h32, 8'h50);
      wr(8'h34, 8'hff);
      wr(8'h36, 8'h00);
      autoMode <= 1'b1;
      spinUp;
      for (c = 0; c < 16; c++) begin
         h = $urandom % 4;
         fanSource1 <= h[1:0];
         wr(8'h2c, {h == 0 ? c[3:0] : ~c[3:0], h == 1 ? c[3:0] : ~c[3:0]});
         wr(8'h2d, {h == 2 ? c[3:0] : ~c[3:0], h == 3 ? c[3:0] : ~c[3:0]});
         step(base + WIDE[c*8 +: 8]);
         chk(9'h0ff);
         step(base + WIDE[c*8 +: 8] - 8'h01);
         chk(9'h1ff);
      end
      for (h = 0; h < 4; h++) begin
         fanSource1 <= h[1:0];
         c = 8'h01 + 8'($urandom % 15);
         v = h[0] ? {4'h0, c[3:0]} : {c[3:0], 4'h0};
         wr(8'h2e, h < 2 ? v : 8'h00);
         wr(8'h2f, h < 2 ? 8'h00 : v);
         step(base - c);
         chk(9'h050);
         step(base - c - 8'h01);
         chk(9'h000);
         spinUp;
      end
      for (i = 0; i < 8; i++) begin
         c = 8'(i);
         wr(8'h36, 8'h00);
         step(base);
         chk(9'h050);
         wr(8'h36, {2'h1, ~c[2:0], c[2:0]});
         step(base + 8'h50);
         chk({1'b0, 8'h50 + STEPS[i*8 +: 8]});
         wr(8'h36, {2'h2, c[2:0], ~c[2:0]});
         step(base + 8'h50);
         chk(9'h0ff);
         wr(8'h36, 8'h00);
         step(base);
         faultMode <= 1'b1;
         wr(8'h37, {2'h3, ~c[2:0], c[2:0]});
         step(base);
         chk({1'b0, 8'h50 + STEPS[i*8 +: 8]});
         faultMode <= 1'b0;
      end
      wr(8'h34, 8'h70);
      step(base + 8'h50);
      chk(9'h070);
      autoMode <= 1'b0;
      step(base + 8'h50);
      chk(9'h000);
      wr(8'h31, 8'ha0);
      wr(8'h33, 8'h40);
      wr(8'h35, 8'h58);
      autoMode <= 1'b1;
      step(base + 8'h01);
      chk2(9'h1a0);
      for (i = 0; i < 200 && fanStarting2 !== 1'b0; i++)
         @(posedge ref_clk);
      chk2(9'h040);
      step(base + 8'h50);
      chk2(9'h058);
      autoMode <= 1'b0;
      step(base);
      chk2(9'h000);
      repeat (4) @(posedge ref_clk);
      wrap_up;
   end
endmodule

//--- tb/fan_loop_props.sv
/* assertions on the fan one drive path and register port
   sees top ports only; keeps a shadow of register writes */
`timescale 1ns/1ps
module fan_loop_props (
   input wire ref_clk,
   input wire rst,
   input wire regWrite,
   input wire regRead,
   input wire [7:0] regAddr,
   input wire [7:0] regWdata,
   input wire [7:0] regRdata,
   input wire stepEn,
   input wire autoMode,
   input wire faultMode,
   input wire tach1,
   input wire [7:0] fanOutputOne,
   input wire fanStarting1
);
   localparam [63:0] STEPS = {8'h30, 8'h18, 8'h0c, 8'h08, 8'h05, 8'h03, 8'h02, 8'h01};
   reg [7:0] start_q, min_q, ceil_q, quiet_q, fault_q;
   reg [1:0] tachCnt_q;
   wire [8:0] quietStep = {1'b0, STEPS[quiet_q[2:0]*8 +: 8]};
   wire [7:0] faultStep = STEPS[fault_q[2:0]*8 +: 8];
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         start_q <= 8'h80;
         min_q <= 8'h60;
         ceil_q <= 8'h20;
         quiet_q <= 8'h3f;
         fault_q <= 8'h3f;
         tachCnt_q <= 2'h0;
      end else begin
         tachCnt_q <= fanStarting1 ? tachCnt_q + {1'b0, tach1} : 2'h0;
         if (regWrite) begin
            case (regAddr)
               8'h30: start_q <= regWdata;
               8'h32: min_q <= regWdata;
               8'h34: ceil_q <= regWdata;
               8'h36: quiet_q <= regWdata;
               8'h37: fault_q <= regWdata;
               default: ;
            endcase
         end
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   property p_start_level;
      $rose(fanStarting1) |-> fanOutputOne == start_q;
   endproperty
   a_start_level: assert property (p_start_level) else $error("start level wrong");
   property p_start_end;
      fanStarting1 && tach1 && tachCnt_q == 2'h1 |=> !fanStarting1;
   endproperty
   a_start_end: assert property (p_start_end) else $error("start not ended");
   property p_exit_level;
      $fell(fanStarting1) && $past(tach1) |-> fanOutputOne == min_q;
   endproperty
   a_exit_level: assert property (p_exit_level) else $error("exit level wrong");
   property p_off;
      !autoMode && !faultMode |=> fanOutputOne == 8'h00 && !fanStarting1;
   endproperty
   a_off: assert property (p_off) else $error("drive not off");
   property p_ceiling;
      $past(autoMode) && !$past(faultMode) && !$past(fanStarting1) && !fanStarting1
         && fanOutputOne > $past(fanOutputOne) |-> fanOutputOne <= $past(ceil_q);
   endproperty
   a_ceiling: assert property (p_ceiling) else $error("drive above ceiling");
   property p_quiet;
      $past(quiet_q[6]) && $past(autoMode) && !$past(faultMode) && !$past(fanStarting1) && !fanStarting1
         && $past(fanOutputOne) != 8'h00 && fanOutputOne != 8'h00
         |-> fanOutputOne <= $past(fanOutputOne) + $past(quietStep)
         && $past(fanOutputOne) <= fanOutputOne + $past(quietStep);
   endproperty
   a_quiet: assert property (p_quiet) else $error("quiet step exceeded");
   property p_fault;
      $past(faultMode) && $past(autoMode) && $past(stepEn) && !$past(fanStarting1) && !fanStarting1
         && $past(fanOutputOne) != 8'h00 |-> fanOutputOne == ((9'h0ff - $past(fanOutputOne)
         < $past(faultStep)) ? 8'hff : $past(fanOutputOne) + $past(faultStep));
   endproperty
   a_fault: assert property (p_fault) else $error("fault step wrong");
   property p_top_bits;
      regRead && regAddr == 8'h37 |=> regRdata[7:6] == 2'h0;
   endproperty
   a_top_bits: assert property (p_top_bits) else $error("fault top bits set");
   c_spin: cover property ($fell(fanStarting1) && $past(tach1));
   c_quiet: cover property (quiet_q[6] && stepEn && autoMode);
   c_fault: cover property (faultMode && stepEn && fanOutputOne != 8'h00);
endmodule
bind auto_fan_control_params fan_loop_props u_fan_loop_props (
   .ref_clk, .rst, .regWrite, .regRead, .regAddr, .regWdata, .regRdata, .stepEn,
   .autoMode, .faultMode, .tach1, .fanOutputOne, .fanStarting1
);

//--- tb/fan_tach_model.sv
/* three-wire fan: one tach pulse per period while driven
   assumes drive zero means the fan stands still */
`timescale 1ns/1ps
module fan_tach_model #(parameter int PERIOD = 16) (
   input wire refClk,
   input wire rst,
   input wire [7:0] drive,
   output reg tachPulse
);
   reg [7:0] cnt_q;
   always @(posedge refClk or posedge rst) begin
      if (rst) begin
         cnt_q <= 8'h00;
         tachPulse <= 1'b0;
      end else begin
         tachPulse <= drive != 8'h00 && cnt_q == PERIOD - 1;
         cnt_q <= (drive == 8'h00 || cnt_q == PERIOD - 1) ? 8'h00 : cnt_q + 8'h01;
      end
   end
endmodule
